// File: hdl/srw_debounce.sv
// Debounce filter for an active-low level input.
// Assumes the input is already synchronous to clk_sys.
`timescale 1ns/100ps
module srw_debounce #(
  parameter int QUAL_CYC = 5
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic level_in,
  output logic      level_out
);
  localparam int CW = $clog2(QUAL_CYC + 1);
  logic [CW-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Output follows the input only after it has been stable QUAL_CYC cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg   <= '0;
      level_out <= 1'b1;
    end else if (level_in == level_out) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(QUAL_CYC - 1)) begin
      cnt_reg   <= '0;
      level_out <= level_in;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end
endmodule : srw_debounce

// File: hdl/srw_pkg.sv
// Package for the supervisory reset and watchdog block.
// Assumes a single 40 MHz system clock.
package srw_pkg;
  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS       = 25000;   // 40 MHz
  // Manual input low time that must produce a reset
  localparam int MANUAL_MIN_LOW_NS   = 1000;
  // Manual input glitch length that must be ignored
  localparam int MANUAL_GLITCH_NS    = 100;
  // Shortest strobe pulse that still counts as a service
  localparam int STROBE_MIN_PULSE_NS = 50;
  // Debounce qualify count: above the glitch, at most the minimum low time
  localparam int MANUAL_QUAL_CYC     = (MANUAL_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  // Watchdog period and reset hold period defaults
  localparam int WATCHDOG_PERIOD_MS  = 1600;
  localparam int RESET_HOLD_MS       = 140;
  localparam longint WATCHDOG_PERIOD_CYC = longint'(WATCHDOG_PERIOD_MS) * 1000000000 / CLK_PERIOD_PS;
  localparam longint RESET_HOLD_CYC      = (longint'(RESET_HOLD_MS) * 1000000000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  // Width of the long counters
  localparam int CNT_W               = 32;
  // Output stage variants
  localparam int OUT_LOW_ONLY        = 0;
  localparam int OUT_COMPLEMENTARY   = 1;
  // Reset state machine
  typedef enum logic [1:0] {
    SRW_ASSERT = 2'b01,
    SRW_IDLE   = 2'b10
  } srw_state_type;
endpackage : srw_pkg

// File: hdl/srw_supervisor.sv
// Supervisory reset generator with watchdog and manual reset.
// Assumes one free-running clock; nrst comes from a power-on cell only.
//
// Overview of operation
// - Reset is asserted whenever the undervoltage input is high, regardless of the other inputs.
// - A manual reset input held low for at least 1 us produces a reset.
// - The manual input rests high when unconnected, meaning no request.
// - Low glitches on the manual input up to about 100 ns are ignored and the input is debounced.
// - With the watchdog fitted, a strobe held at one level for the whole watchdog period causes reset.
// - Any strobe edge clears the watchdog timer, and any reset also clears it.
// - Reset is asserted for undervoltage, manual request or watchdog expiry.
// - Reset stays asserted for the hold period after the last request ends, then deasserts.
// - Outputs are either active-low only or complementary low and high carrying the same state.
// - Manual and watchdog functions are each enabled by a build parameter.
// - The watchdog timer is held cleared while reset is asserted.
// - A disable input stops watchdog expiry from ever causing reset.
// - Strobe pulses of 50 ns or more are seen as a service.
`timescale 1ns/100ps
module srw_supervisor #(
  parameter int          OUT_VARIANT  = srw_pkg::OUT_COMPLEMENTARY,
  parameter bit          HAS_MANUAL   = 1'b1,
  parameter bit          HAS_WATCHDOG = 1'b1,
  parameter logic [31:0] WDOG_CYC     = 32'(srw_pkg::WATCHDOG_PERIOD_CYC),
  parameter logic [31:0] HOLD_CYC     = 32'(srw_pkg::RESET_HOLD_CYC)
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic supply_low,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_strobe_in,
  input  wire logic watchdog_disable,
  output logic      reset_out_n,
  output logic      reset_out
);
  localparam int W = srw_pkg::CNT_W;

  srw_pkg::srw_state_type state_reg;
  logic [W-1:0] hold_reg;
  logic [W-1:0] wdog_reg;
  logic         man_s1_reg;
  logic         man_s2_reg;
  logic         wdi_s1_reg;
  logic         wdi_s2_reg;
  logic         wdi_d_reg;
  logic         man_clean;
  logic         man_req;
  logic         wdog_expire;
  logic         strobe_edge;
  logic         request;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two stages each; manual rests high like a pulled-up pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      man_s1_reg <= 1'b1;
      man_s2_reg <= 1'b1;
      wdi_s1_reg <= 1'b0;
      wdi_s2_reg <= 1'b0;
      wdi_d_reg  <= 1'b0;
    end else begin
      man_s1_reg <= manual_reset_n;
      man_s2_reg <= man_s1_reg;
      wdi_s1_reg <= watchdog_strobe_in;
      wdi_s2_reg <= wdi_s1_reg;
      wdi_d_reg  <= wdi_s2_reg;
    end
  end

  // Glitch filter and debounce on the manual input
  srw_debounce #(
    .QUAL_CYC  (srw_pkg::MANUAL_QUAL_CYC)
  ) u_man_db (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .level_in  (man_s2_reg),
    .level_out (man_clean)
  );

  // ----------------------------------------------------------------
  // Request combination
  // ----------------------------------------------------------------
  // Any edge is a service; 50 ns spans two clock cycles so it is sampled
  assign strobe_edge = wdi_s2_reg ^ wdi_d_reg;
  assign man_req     = HAS_MANUAL && !man_clean;
  assign wdog_expire = HAS_WATCHDOG && !watchdog_disable
                       && (wdog_reg >= WDOG_CYC - 32'(1)) && !strobe_edge;
  assign request     = supply_low || man_req || wdog_expire;

  // ----------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------
  // Cleared by edges and held clear throughout reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wdog_reg <= '0;
    end else if (state_reg == srw_pkg::SRW_ASSERT || request || strobe_edge
                 || !HAS_WATCHDOG || watchdog_disable) begin
      wdog_reg <= '0;
    end else begin
      wdog_reg <= wdog_reg + 32'(1);
    end
  end

  // ----------------------------------------------------------------
  // Reset stretch state machine
  // ----------------------------------------------------------------
  // Hold count reloads while any request stands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= srw_pkg::SRW_ASSERT;
      hold_reg  <= HOLD_CYC;
    end else begin
      unique case (state_reg)
        srw_pkg::SRW_ASSERT: begin
          if (request) begin
            hold_reg <= HOLD_CYC;
          end else if (hold_reg <= 32'(1)) begin
            state_reg <= srw_pkg::SRW_IDLE;
            hold_reg  <= '0;
          end else begin
            hold_reg <= hold_reg - 32'(1);
          end
        end
        srw_pkg::SRW_IDLE: begin
          if (request) begin
            state_reg <= srw_pkg::SRW_ASSERT;
            hold_reg  <= HOLD_CYC;
          end
        end
        default: begin
          state_reg <= srw_pkg::SRW_ASSERT;
          hold_reg  <= HOLD_CYC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Registered outputs; low-only variant holds the high output at zero
  // In the complementary variant both outputs show the asserted state during nrst, so the pair never disagrees
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_out_n <= 1'b0;
      reset_out   <= (OUT_VARIANT == srw_pkg::OUT_COMPLEMENTARY);
    end else begin
      reset_out_n <= !(request || state_reg == srw_pkg::SRW_ASSERT);
      reset_out   <= (OUT_VARIANT == srw_pkg::OUT_COMPLEMENTARY)
                     && (request || state_reg == srw_pkg::SRW_ASSERT);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_req_end;
    request ##1 !request;
  endsequence

  a_supply_forces_rst: assert property (@(posedge clk_sys) disable iff (!nrst)
    supply_low |=> !reset_out_n) else $error("supply low without reset");
  a_manual_forces_rst: assert property (@(posedge clk_sys) disable iff (!nrst)
    man_req |=> !reset_out_n) else $error("manual request without reset");
  a_glitch_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(man_s2_reg) ##1 $rose(man_s2_reg) |-> man_clean) else $error("glitch passed");
  a_hold_stretch: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_req_end |=> !reset_out_n [*8]) else $error("reset released early");
  a_wdog_clear_rst: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == srw_pkg::SRW_ASSERT |=> wdog_reg == '0) else $error("watchdog ran in reset");
  a_edge_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
    strobe_edge |=> wdog_reg == '0) else $error("edge did not clear watchdog");
  a_disable_blocks: assert property (@(posedge clk_sys) disable iff (!nrst)
    watchdog_disable |-> !wdog_expire) else $error("disabled watchdog expired");
  a_outputs_match: assert property (@(posedge clk_sys) disable iff (!nrst)
    OUT_VARIANT == srw_pkg::OUT_COMPLEMENTARY |-> reset_out == !reset_out_n)
    else $error("outputs disagree");
  a_expire_resets: assert property (@(posedge clk_sys) disable iff (!nrst)
    wdog_expire |=> !reset_out_n ##1 state_reg == srw_pkg::SRW_ASSERT)
    else $error("expiry without reset");

  // ----------------------------------------------------------------
  // Assertions on counters and qualification
  // ----------------------------------------------------------------
  // Manual input held low long enough for the debounce to accept it
  sequence s_man_held;
    !man_s2_reg [*5];
  endsequence

  // Released state with nothing asking for reset
  sequence s_idle_quiet;
    state_reg == srw_pkg::SRW_IDLE && !request;
  endsequence

  a_manual_qualify: assert property (@(posedge clk_sys) disable iff (!nrst)
    HAS_MANUAL && s_man_held |=> man_req) else $error("held manual low not accepted");
  a_idle_release: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_idle_quiet |=> reset_out_n) else $error("reset without request");
  a_reload_on_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    request |=> state_reg == srw_pkg::SRW_ASSERT && hold_reg == HOLD_CYC)
    else $error("hold period not reloaded");
  a_hold_counts: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == srw_pkg::SRW_ASSERT && !request && hold_reg > 32'(1) |=> hold_reg == $past(hold_reg) - 32'(1))
    else $error("hold counter skipped");
  a_req_clears_wdog: assert property (@(posedge clk_sys) disable iff (!nrst)
    request |=> wdog_reg == '0) else $error("reset did not clear watchdog");
  a_wdog_counts: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_idle_quiet and (HAS_WATCHDOG && !watchdog_disable && !strobe_edge) |=> wdog_reg == $past(wdog_reg) + 32'(1))
    else $error("watchdog did not count");
  a_expire_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    wdog_expire |-> state_reg == srw_pkg::SRW_IDLE) else $error("watchdog expired during reset");
  a_low_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    OUT_VARIANT == srw_pkg::OUT_LOW_ONLY |-> !reset_out) else $error("high output driven in low-only variant");
endmodule : srw_supervisor

// File: tb/srw_cpu_model.sv
// Processor model that services the supervisor's watchdog strobe.
// Assumes its run input is driven on the falling clock edge.
`timescale 1ns/100ps
module srw_cpu_model #(
  parameter int TOGGLE_CYC = 60
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      watchdog_strobe_in
);
  int cnt;
  initial begin
    watchdog_strobe_in = 1'b0;
    cnt = 0;
  end
  // Strobe toggles every TOGGLE_CYC cycles while running, stands still when stopped
  always @(posedge clk_sys) begin
    cnt <= (run && cnt < TOGGLE_CYC - 1) ? cnt + 1 : 0;
    if (run && cnt == TOGGLE_CYC - 1) watchdog_strobe_in <= ~watchdog_strobe_in;
  end
endmodule // srw_cpu_model

// File: tb/supervisory_reset_watchdog_tb.sv
// Self-checking bench for the supervisory reset generator.
// Assumes shortened watchdog and hold periods set by parameter.
`timescale 1ns/100ps
module supervisory_reset_watchdog_tb;
  localparam int WD = 200;
  localparam int HD = 20;
  typedef struct {int sup; int man; int len; logic exp;} srw_row_type;
  logic      clk_sys, nrst, supply_low, manual_reset_n, watchdog_disable, run;
  wire logic watchdog_strobe_in, reset_out_n, reset_out;
  int        failures = 0, comparisons = 0, cycles = 0;
  // Rows: supply low cycles, manual low cycles, drive length, reset expected
  srw_row_type rows[7] = '{'{1, 0, 4, 1'b1}, '{30, 0, 30, 1'b1}, '{0, 1, 1, 1'b0}, '{0, 2, 2, 1'b0},
                           '{0, 4, 4, 1'b0}, '{0, 40, 40, 1'b1}, '{10, 40, 40, 1'b1}};

  srw_supervisor #(.OUT_VARIANT(srw_pkg::OUT_COMPLEMENTARY), .HAS_MANUAL(1'b1), .HAS_WATCHDOG(1'b1),
                   .WDOG_CYC(32'h0000_00C8), .HOLD_CYC(32'h0000_0014)) srw_supervisor_i (
    .clk_sys(clk_sys), .nrst(nrst), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
    .watchdog_strobe_in(watchdog_strobe_in), .watchdog_disable(watchdog_disable),
    .reset_out_n(reset_out_n), .reset_out(reset_out));
  srw_cpu_model #(.TOGGLE_CYC(60)) srw_cpu_model_i (
    .clk_sys(clk_sys), .run(run), .watchdog_strobe_in(watchdog_strobe_in));

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Waits for reset_out_n to reach lvl, checks the cycle count and the complement
  task automatic wait_for(string name, logic lvl, int lo, int hi);
    int n;
    n = 0;
    while (reset_out_n !== lvl && n <= hi) begin
      @(negedge clk_sys);
      n++;
      check("reset_out", ~reset_out_n, reset_out);
    end
    check(name, 1'b1, n >= lo && n <= hi);
  endtask
  task automatic run_row(srw_row_type r);
    int   n;
    logic seen;
    seen = 1'b0;
    for (n = 0; n < r.len; n++) begin
      supply_low = (n < r.sup);
      manual_reset_n = !(n < r.man);
      @(negedge clk_sys);
      if (reset_out_n === 1'b0) seen = 1'b1;
    end
    supply_low = 1'b0;
    manual_reset_n = 1'b1;
    if (r.exp) begin
      check("asserted", 1'b1, seen);
      wait_for("hold", 1'b1, HD + (r.sup > r.man ? r.sup : r.man) - r.len, HD + 12);
    end else begin
      repeat (15) begin
        @(negedge clk_sys);
        if (reset_out_n === 1'b0) seen = 1'b1;
      end
      check("asserted", 1'b0, seen);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    supply_low = 1'b0;
    manual_reset_n = 1'b1;
    watchdog_disable = 1'b0;
    run = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("reset_out_n", 1'b0, reset_out_n);
    check("reset_out", 1'b1, reset_out);
    nrst = 1'b1;
    wait_for("power_up", 1'b1, HD, HD + 3);
    foreach (rows[i]) run_row(rows[i]);
    // Watchdog expiry: stop right after a strobe edge
    @(watchdog_strobe_in);
    @(negedge clk_sys);
    run = 1'b0;
    wait_for("expiry", 1'b0, WD - 2, WD + 6);
    wait_for("expiry_hold", 1'b1, HD, HD + 3);
    wait_for("rearm", 1'b0, WD - 2, WD + 4);
    run = 1'b1;
    wait_for("recover", 1'b1, HD, HD + 3);
    // Disabled watchdog never expires
    @(watchdog_strobe_in);
    @(negedge clk_sys);
    watchdog_disable = 1'b1;
    run = 1'b0;
    repeat (2 * WD) begin
      @(negedge clk_sys);
      check("disabled", 1'b1, reset_out_n);
    end
    run = 1'b1;
    repeat (3) @(negedge clk_sys);
    watchdog_disable = 1'b0;
    repeat (2 * WD) begin
      @(negedge clk_sys);
      check("serviced", 1'b1, reset_out_n);
    end
    // Second reset in mid-run
    nrst = 1'b0;
    @(negedge clk_sys);
    check("reset_out_n", 1'b0, reset_out_n);
    check("reset_out", 1'b1, reset_out);
    nrst = 1'b1;
    wait_for("re_power_up", 1'b1, HD, HD + 3);
    complete_run();
  end
endmodule // supervisory_reset_watchdog_tb
